// ### core/mcs_consts.svh
// Register offsets, field positions, reset values and sizes of the measurement channel sequencer.
`ifndef MCS_CONSTS_SVH
`define MCS_CONSTS_SVH

`define MCS_RES_W 10
`define MCS_AVG_LOG2 4
`define MCS_SLOTS 6

`define MCS_ADDR_STATUS1 8'h00
`define MCS_ADDR_STATUS2 8'h01
`define MCS_ADDR_LOW_A 8'h03
`define MCS_ADDR_LOW_B 8'h04
`define MCS_ADDR_MSB_FIRST 8'h06
`define MCS_ADDR_MSB_LAST 8'h0B
`define MCS_ADDR_CTRL1 8'h18
`define MCS_ADDR_CTRL2 8'h19
`define MCS_ADDR_CTRL3 8'h1A
`define MCS_ADDR_MASK2 8'h1E
`define MCS_ADDR_TOFFS 8'h1F
`define MCS_ADDR_VHIGH 8'h23
`define MCS_ADDR_VLOW 8'h24

`define MCS_C1_MON_EN 0
`define MCS_C1_PIN_LO 1
`define MCS_C1_INT_POL 3
`define MCS_PINS_ANALOG 2'h3
`define MCS_C2_SEL_LO 0
`define MCS_C2_SINGLE 4
`define MCS_C2_AVG_DIS 5
`define MCS_C3_DAC_REF_INT 0
`define MCS_C3_AIN_REF_VDD 4
`define MCS_S2_SUPPLY 0

`define MCS_CTRL1_RST 8'h00
`define MCS_CTRL2_RST 8'h00
`define MCS_CTRL3_RST 8'h00
`define MCS_MASK2_RST 8'h00
`define MCS_VHIGH_RST 8'hFF
`define MCS_VLOW_RST 8'h00

`endif

// ### core/mcs_pkg.sv
// Types shared by the measurement channel sequencer modules.
`default_nettype none
package mcs_pkg;
    typedef enum logic [1:0] {MCS_IDLE, MCS_START, MCS_WAIT} mcs_phase_t;
    typedef enum logic [2:0] {
        MCS_CH_SUPPLY, MCS_CH_INT, MCS_CH_EXT, MCS_CH_ANALOG_INPUT_ONE, MCS_CH_ANALOG_INPUT_TWO, MCS_CH_ANALOG_INPUT_THREE, MCS_CH_ANALOG_INPUT_FOUR
    } mcs_chan_t;
endpackage
`default_nettype wire

// ### core/mcs_avg_if.sv
// Sample and result signals between the sequencer and its averager.
`default_nettype none
interface mcs_avg_if;
    logic push;
    logic clear;
    logic [9:0] sample;
    logic done;
    logic [9:0] avg;
    modport src (output push, output clear, output sample, input done, input avg);
    modport acc (input push, input clear, input sample, output done, output avg);
endinterface
`default_nettype wire

// ### core/mcs_averager.sv
// Accumulator that averages a fixed power-of-two count of two's complement samples.
`include "mcs_consts.svh"
`default_nettype none
module mcs_averager
    import mcs_pkg::*;
#(
    parameter int LOG2_N = `MCS_AVG_LOG2
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    mcs_avg_if.acc avg_io
);
    typedef struct packed {
        logic [LOG2_N-1:0] count;
        logic [9+LOG2_N:0] sum;
    } mcs_avg_st_t;

    mcs_avg_st_t s;
    mcs_avg_st_t next_s;
    logic [9+LOG2_N:0] sum_in;

    // Sign extension keeps negative temperatures correct through the sum.
    assign sum_in = s.sum + {{LOG2_N{avg_io.sample[9]}}, avg_io.sample};
    assign avg_io.done = avg_io.push && (&s.count);
    assign avg_io.avg = sum_in[9+LOG2_N:LOG2_N];

    always_comb begin
        next_s = s;
        if (avg_io.clear) begin
            next_s = '0;
        end else if (avg_io.push) begin
            if (&s.count) begin
                next_s = '0;
            end else begin
                next_s.sum = sum_in;
                next_s.count = s.count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule
`default_nettype wire

// ### core/mcs_sequencer.sv
// Conversion sequencer, result store and limit check of the shared measurement converter.
//
// Summary of operation
// - Supply result split: low bits 03h, high 06h.
// - Supply compared to limits; unmasked fault flags, interrupt.
// - Supply scaled so 7 V reads 3FF.
// - Reference amplifier powered while monitoring enabled.
// - Internal reference for supply and temperature channels.
// - Converter outputs use external reference after power-up.
// - Power-up: round robin, idle until enable bit.
// - Round robin order supply, internal, external/inputs, three, four.
// - Shared pins convert as diode or two inputs.
// - Single bit in 19h selects single-channel mode.
// - Single mode repeats selected channel back to back.
// - Select zero is supply, one is internal.
// - Serial traffic halts conversion; resumes afterwards.
// - Internal temperature stored in two's complement.
// - Offset register added before internal temperature stored.
// - Remote temperature averaged over sixteen conversions.
// - Diode bias alternates between two currents.
// - Internal temperature averaging on by default, bit five disables.
// - One result step equals a quarter degree.
// - Low-byte read freezes high bytes; high read releases.
// - Two-bit field chooses shared pin function.
`include "mcs_consts.svh"
`default_nettype none
module mcs_sequencer
    import mcs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic serial_busy,
    input wire logic adc_done,
    input wire logic [9:0] adc_data,
    output logic adc_start,
    output logic adc_abort,
    output logic [2:0] adc_chan,
    output logic adc_ref_internal,
    output logic ref_amp_on,
    output logic dac_ref_internal,
    output logic diode_bias_high,
    output logic shared_pins_analog,
    output logic int_out
);
    typedef struct packed {
        mcs_phase_t phase;
        mcs_chan_t chan;
        mcs_chan_t conv_chan;
        logic [`MCS_SLOTS-1:0][9:0] res;
        logic [`MCS_SLOTS-1:0][7:0] msb_view;
        logic [`MCS_SLOTS-1:0] lock;
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic [7:0] ctrl3;
        logic [7:0] mask2;
        logic [7:0] status2;
        logic [7:0] toffs;
        logic [7:0] vhigh;
        logic [7:0] vlow;
        logic [7:0] rdata;
        logic adc_start;
        logic adc_abort;
        logic adc_ref_int;
        logic ref_amp;
        logic dac_ref_int;
        logic bias;
        logic pins_analog;
        logic int_out;
    } mcs_st_t;

    mcs_st_t s;
    mcs_st_t next_s;
    mcs_avg_if avg_io ();

    // Result slot of a channel; the remote diode and the first input share one slot.
    function automatic logic [2:0] slot_of(input mcs_chan_t ch);
        case (ch)
            MCS_CH_SUPPLY: slot_of = 3'h0;
            MCS_CH_INT: slot_of = 3'h1;
            MCS_CH_EXT: slot_of = 3'h2;
            MCS_CH_ANALOG_INPUT_ONE: slot_of = 3'h2;
            MCS_CH_ANALOG_INPUT_TWO: slot_of = 3'h3;
            MCS_CH_ANALOG_INPUT_THREE: slot_of = 3'h4;
            MCS_CH_ANALOG_INPUT_FOUR: slot_of = 3'h5;
            default: slot_of = 3'h0;
        endcase
    endfunction

    function automatic mcs_chan_t decode_sel(input logic [2:0] sel, input logic analog);
        case (sel)
            3'h0: decode_sel = MCS_CH_SUPPLY;
            3'h1: decode_sel = MCS_CH_INT;
            3'h2: decode_sel = analog ? MCS_CH_ANALOG_INPUT_ONE : MCS_CH_EXT;
            3'h3: decode_sel = analog ? MCS_CH_ANALOG_INPUT_TWO : MCS_CH_EXT;
            3'h4: decode_sel = MCS_CH_ANALOG_INPUT_THREE;
            3'h5: decode_sel = MCS_CH_ANALOG_INPUT_FOUR;
            default: decode_sel = MCS_CH_SUPPLY;
        endcase
    endfunction

    // Successor in the round robin; the third slot converts whichever pin function is set.
    function automatic mcs_chan_t next_rr(input mcs_chan_t ch, input logic analog);
        case (ch)
            MCS_CH_SUPPLY: next_rr = MCS_CH_INT;
            MCS_CH_INT: next_rr = analog ? MCS_CH_ANALOG_INPUT_ONE : MCS_CH_EXT;
            MCS_CH_ANALOG_INPUT_ONE: next_rr = MCS_CH_ANALOG_INPUT_TWO;
            MCS_CH_EXT: next_rr = MCS_CH_ANALOG_INPUT_THREE;
            MCS_CH_ANALOG_INPUT_TWO: next_rr = MCS_CH_ANALOG_INPUT_THREE;
            MCS_CH_ANALOG_INPUT_THREE: next_rr = MCS_CH_ANALOG_INPUT_FOUR;
            default: next_rr = MCS_CH_SUPPLY;
        endcase
    endfunction

    function automatic logic [7:0] read_reg(input mcs_st_t st, input logic [7:0] addr);
        logic [2:0] idx;
        idx = 3'(addr - `MCS_ADDR_MSB_FIRST);
        read_reg = 8'h00;
        if (addr == `MCS_ADDR_STATUS2) begin
            read_reg = st.status2;
        end else if (addr == `MCS_ADDR_LOW_A) begin
            read_reg = {4'h0, st.res[1][1:0], st.res[0][1:0]};
        end else if (addr == `MCS_ADDR_LOW_B) begin
            read_reg = {st.res[5][1:0], st.res[4][1:0], st.res[3][1:0], st.res[2][1:0]};
        end else if (addr >= `MCS_ADDR_MSB_FIRST && addr <= `MCS_ADDR_MSB_LAST) begin
            read_reg = st.msb_view[idx];
        end else if (addr == `MCS_ADDR_CTRL1) begin
            read_reg = st.ctrl1;
        end else if (addr == `MCS_ADDR_CTRL2) begin
            read_reg = st.ctrl2;
        end else if (addr == `MCS_ADDR_CTRL3) begin
            read_reg = st.ctrl3;
        end else if (addr == `MCS_ADDR_MASK2) begin
            read_reg = st.mask2;
        end else if (addr == `MCS_ADDR_TOFFS) begin
            read_reg = st.toffs;
        end else if (addr == `MCS_ADDR_VHIGH) begin
            read_reg = st.vhigh;
        end else if (addr == `MCS_ADDR_VLOW) begin
            read_reg = st.vlow;
        end
    endfunction

    logic mon_en;
    logic single;
    logic analog;
    logic avg_dis;
    logic needs_avg;
    mcs_chan_t cur;
    logic [9:0] value;
    logic [2:0] slot;

    assign mon_en = s.ctrl1[`MCS_C1_MON_EN];
    assign single = s.ctrl2[`MCS_C2_SINGLE];
    assign analog = s.ctrl1[`MCS_C1_PIN_LO+:2] == `MCS_PINS_ANALOG;
    assign avg_dis = s.ctrl2[`MCS_C2_AVG_DIS];
    // A round robin position left on a pin function that was since changed follows the new function.
    assign cur = single ? decode_sel(s.ctrl2[`MCS_C2_SEL_LO+:3], analog) :
        ((analog && s.chan == MCS_CH_EXT) ? MCS_CH_ANALOG_INPUT_ONE :
        ((!analog && (s.chan == MCS_CH_ANALOG_INPUT_ONE || s.chan == MCS_CH_ANALOG_INPUT_TWO)) ? MCS_CH_EXT : s.chan));
    assign needs_avg = (s.conv_chan == MCS_CH_EXT) || (s.conv_chan == MCS_CH_INT && !avg_dis);
    assign slot = slot_of(s.conv_chan);

    assign avg_io.push = (s.phase == MCS_WAIT) && adc_done && !serial_busy && mon_en && needs_avg;
    // A change of channel drops any partial sum, so an average never mixes two channels.
    assign avg_io.clear = ((s.phase == MCS_WAIT) && (serial_busy || !mon_en)) ||
        ((s.phase == MCS_START) && (cur != s.conv_chan));
    assign avg_io.sample = adc_data;

    // Raw codes are two's complement, a quarter degree per step; the offset is sign-extended.
    assign value = (s.conv_chan == MCS_CH_INT) ?
        (needs_avg ? avg_io.avg : adc_data) + {{2{s.toffs[7]}}, s.toffs} :
        (needs_avg ? avg_io.avg : adc_data);

    mcs_averager #(
        .LOG2_N(`MCS_AVG_LOG2)
    ) u_avg (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .avg_io(avg_io)
    );

    always_comb begin
        next_s = s;
        next_s.adc_start = 1'b0;
        next_s.adc_abort = 1'b0;

        if (reg_rd) begin
            next_s.rdata = read_reg(s, reg_addr);
            if (reg_addr == `MCS_ADDR_STATUS2) begin
                next_s.status2 = 8'h00;
            end else if (reg_addr == `MCS_ADDR_LOW_A) begin
                next_s.lock[1:0] = 2'h3;
            end else if (reg_addr == `MCS_ADDR_LOW_B) begin
                next_s.lock[5:2] = 4'hF;
            end else if (reg_addr >= `MCS_ADDR_MSB_FIRST && reg_addr <= `MCS_ADDR_MSB_LAST) begin
                next_s.lock = '0;
            end
        end

        if (reg_wr) begin
            case (reg_addr)
                `MCS_ADDR_CTRL1: next_s.ctrl1 = reg_wdata;
                `MCS_ADDR_CTRL2: next_s.ctrl2 = reg_wdata;
                `MCS_ADDR_CTRL3: next_s.ctrl3 = reg_wdata;
                `MCS_ADDR_MASK2: next_s.mask2 = reg_wdata;
                `MCS_ADDR_TOFFS: next_s.toffs = reg_wdata;
                `MCS_ADDR_VHIGH: next_s.vhigh = reg_wdata;
                `MCS_ADDR_VLOW: next_s.vlow = reg_wdata;
                default: next_s.ctrl1 = next_s.ctrl1;
            endcase
        end

        case (s.phase)
            MCS_IDLE: begin
                if (mon_en && !serial_busy) begin
                    next_s.phase = MCS_START;
                end
            end
            MCS_START: begin
                if (serial_busy || !mon_en) begin
                    next_s.phase = MCS_IDLE;
                end else begin
                    next_s.conv_chan = cur;
                    next_s.adc_start = 1'b1;
                    next_s.bias = (cur == MCS_CH_EXT) ? !s.bias : 1'b0;
                    next_s.adc_ref_int = (cur == MCS_CH_SUPPLY || cur == MCS_CH_INT || cur == MCS_CH_EXT) ?
                        1'b1 : !s.ctrl3[`MCS_C3_AIN_REF_VDD];
                    next_s.phase = MCS_WAIT;
                end
            end
            MCS_WAIT: begin
                if (serial_busy || !mon_en) begin
                    // Results stay as they were; the averager restarts from zero.
                    next_s.adc_abort = 1'b1;
                    next_s.bias = 1'b0;
                    next_s.phase = MCS_IDLE;
                end else if (adc_done) begin
                    next_s.phase = MCS_START;
                    if (!needs_avg || avg_io.done) begin
                        next_s.res[slot] = value;
                        if (s.conv_chan == MCS_CH_SUPPLY && !s.mask2[`MCS_S2_SUPPLY] &&
                            (value[9:2] > s.vhigh || value[9:2] <= s.vlow)) begin
                            next_s.status2[`MCS_S2_SUPPLY] = 1'b1;
                        end
                        if (!single) begin
                            next_s.chan = next_rr(s.conv_chan, analog);
                        end
                    end
                end
            end
            default: next_s.phase = MCS_IDLE;
        endcase

        for (int i = 0; i < `MCS_SLOTS; i++) begin
            // The lock taken by this very read also holds back a result that lands in the same cycle.
            if (!next_s.lock[i]) begin
                next_s.msb_view[i] = next_s.res[i][9:2];
            end
        end

        next_s.ref_amp = next_s.ctrl1[`MCS_C1_MON_EN];
        next_s.dac_ref_int = next_s.ctrl3[`MCS_C3_DAC_REF_INT];
        next_s.pins_analog = next_s.ctrl1[`MCS_C1_PIN_LO+:2] == `MCS_PINS_ANALOG;
        next_s.int_out = next_s.ctrl1[`MCS_C1_INT_POL] ? (|next_s.status2) : !(|next_s.status2);
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s <= '0;
            s.ctrl1 <= `MCS_CTRL1_RST;
            s.ctrl2 <= `MCS_CTRL2_RST;
            s.ctrl3 <= `MCS_CTRL3_RST;
            s.mask2 <= `MCS_MASK2_RST;
            s.vhigh <= `MCS_VHIGH_RST;
            s.vlow <= `MCS_VLOW_RST;
            s.int_out <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign adc_start = s.adc_start;
    assign adc_abort = s.adc_abort;
    assign adc_chan = s.conv_chan;
    assign adc_ref_internal = s.adc_ref_int;
    assign ref_amp_on = s.ref_amp;
    assign dac_ref_internal = s.dac_ref_int;
    assign diode_bias_high = s.bias;
    assign shared_pins_analog = s.pins_analog;
    assign int_out = s.int_out;
endmodule
`default_nettype wire

// ### dv/mcs_sequencer_sva.sv
// Concurrent checks on the ports of the measurement channel sequencer.
`default_nettype none
module mcs_sequencer_sva (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic serial_busy,
    input wire logic adc_start,
    input wire logic [2:0] adc_chan,
    input wire logic adc_ref_internal,
    input wire logic ref_amp_on,
    input wire logic dac_ref_internal,
    input wire logic shared_pins_analog
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Order is judged from the third start after a mode write or a pause, since a start already queued may
    // still use the old setting.
    logic single_q;
    logic [1:0] n_ok;
    logic [2:0] last_ch;
    wire logic cfg_wr = reg_wr && (reg_addr == 8'h18 || reg_addr == 8'h19);
    wire logic [2:0] rr_nx = last_ch == 3'h1 ? (shared_pins_analog ? 3'h3 : 3'h2) :
        last_ch == 3'h2 ? 3'h5 : last_ch >= 3'h6 ? 3'h0 : last_ch + 3'h1;
    always_ff @(posedge clk_sys) begin
        if (sys_rst || cfg_wr || serial_busy) begin
            n_ok <= 2'h0;
        end else if (adc_start && n_ok != 2'h2) begin
            n_ok <= n_ok + 2'h1;
        end
        if (sys_rst) begin
            single_q <= 1'b0;
        end else if (reg_wr && reg_addr == 8'h19) begin
            single_q <= reg_wdata[4];
        end
        if (adc_start) begin
            last_ch <= adc_chan;
        end
    end
    property p_amp;
        reg_wr && reg_addr == 8'h18 |=> ref_amp_on == $past(reg_wdata[0]);
    endproperty
    a_amp: assert property (p_amp) else $error("amplifier power does not follow enable");
    property p_go;
        reg_wr && reg_addr == 8'h18 && reg_wdata[0] && !ref_amp_on && !serial_busy |-> ##[2:3] adc_start;
    endproperty
    a_go: assert property (p_go) else $error("no start after enable");
    property p_ref;
        adc_start && adc_chan <= 3'h2 |-> adc_ref_internal;
    endproperty
    a_ref: assert property (p_ref) else $error("external reference on internal channel");
    property p_dac;
        !dac_ref_internal && !(reg_wr && reg_addr == 8'h1A) |=> !dac_ref_internal;
    endproperty
    a_dac: assert property (p_dac) else $error("converter output reference changed unasked");
    property p_halt;
        serial_busy && $past(serial_busy) |-> !adc_start;
    endproperty
    a_halt: assert property (p_halt) else $error("start during serial traffic");
    property p_resume;
        $fell(serial_busy) && ref_amp_on |-> ##[1:3] adc_start;
    endproperty
    a_resume: assert property (p_resume) else $error("no restart after serial traffic");
    property p_rr;
        adc_start && n_ok == 2'h2 && !single_q |->
            adc_chan == rr_nx || (adc_chan == last_ch && (last_ch == 3'h1 || last_ch == 3'h2));
    endproperty
    a_rr: assert property (p_rr) else $error("round robin order broken");
    property p_one;
        adc_start && n_ok == 2'h2 && single_q |-> adc_chan == last_ch;
    endproperty
    a_one: assert property (p_one) else $error("single channel mode changed channel");
endmodule
bind mcs_sequencer mcs_sequencer_sva u_sva (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .serial_busy(serial_busy), .adc_start(adc_start),
    .adc_chan(adc_chan), .adc_ref_internal(adc_ref_internal), .ref_amp_on(ref_amp_on),
    .dac_ref_internal(dac_ref_internal), .shared_pins_analog(shared_pins_analog));
`default_nettype wire

// ### dv/mcs_adc_model.sv
// Behavioural converter that answers each start after a channel-dependent wait.
`default_nettype none
module mcs_adc_model (
    input wire logic clk_sys,
    input wire logic adc_start,
    input wire logic adc_abort,
    input wire logic [2:0] adc_chan,
    output logic adc_done,
    output logic [9:0] adc_data
);
    timeunit 1ns;
    timeprecision 1ns;
    int left = 0;
    logic [9:0] code;
    // Data lines show the inverse of the last code between answers, so a stale sample cannot pass.
    initial begin
        adc_done = 1'b0;
        adc_data = 10'h3FF;
    end
    assign code = adc_chan == 3'h0 ? 10'h2DC : adc_chan == 3'h1 ? 10'h3F5 : adc_chan == 3'h2 ? 10'h064 :
        adc_chan == 3'h5 ? 10'h0C7 : 10'h1FF;
    always @(posedge clk_sys) begin
        adc_done <= 1'b0;
        if (adc_done) begin
            adc_data <= ~adc_data;
        end
        if (adc_start || adc_abort) begin
            left = adc_abort ? 0 : 2 + int'(adc_chan);
        end else if (left == 1) begin
            adc_done <= 1'b1;
            adc_data <= code;
            left = 0;
        end else if (left > 1) begin
            left--;
        end
    end
endmodule
`default_nettype wire

// ### dv/measurement_channel_sequencer_test.sv
// Self-checking bench of the measurement channel sequencer with a converter model.
`default_nettype none
module measurement_channel_sequencer_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic serial_busy = 1'b0;
    logic adc_done, adc_start, adc_abort, adc_ref_internal, ref_amp_on, dac_ref_internal;
    logic diode_bias_high, shared_pins_analog, int_out;
    logic [9:0] adc_data;
    logic [7:0] reg_rdata;
    logic [2:0] adc_chan;
    int mismatches = 0;
    int samples_checked = 0;
    logic [7:0] v;
    logic [2:0] c;
    int n;
    int m;
    // Address in the upper byte, expected byte below it; reading 03h first also exercises the high-byte lock.
    logic [15:0] rows [11] = '{16'h0101, 16'h0200, 16'h0304, 16'h06B7, 16'h07FD, 16'h0819,
        16'h0A31, 16'h0B7F, 16'h04F0, 16'h1801, 16'h23B0};
    logic [2:0] sel_chan [8] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h5, 3'h6, 3'h0, 3'h0};
    always #50 clk_sys = ~clk_sys;
    mcs_sequencer dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .serial_busy(serial_busy),
        .adc_done(adc_done), .adc_data(adc_data), .adc_start(adc_start), .adc_abort(adc_abort),
        .adc_chan(adc_chan), .adc_ref_internal(adc_ref_internal), .ref_amp_on(ref_amp_on),
        .dac_ref_internal(dac_ref_internal), .diode_bias_high(diode_bias_high),
        .shared_pins_analog(shared_pins_analog), .int_out(int_out));
    mcs_adc_model adc (.clk_sys(clk_sys), .adc_start(adc_start), .adc_abort(adc_abort), .adc_chan(adc_chan),
        .adc_done(adc_done), .adc_data(adc_data));
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t ns: seen %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        d = reg_rdata;
        cyc(1);
    endtask
    task automatic next_start(output logic [2:0] ch);
        int k;
        k = 0;
        while (adc_start !== 1'b1 && k < 300) begin
            cyc(1);
            k++;
        end
        check(8'(adc_start), 8'h01);
        ch = adc_chan;
        cyc(1);
    endtask
    task automatic quiet();
        cyc(3);
        repeat (30) begin
            check(8'(adc_start), 8'h00);
            cyc(1);
        end
    endtask
    initial begin
        #(20000 * 100);
        mismatches++;
        report_and_stop();
    end
    initial begin
        cyc(5);
        sys_rst = 1'b0;
        check(8'(int_out), 8'h01);
        check(8'(dac_ref_internal), 8'h00);
        check(8'(ref_amp_on), 8'h00);
        rd(8'h23, v);
        check(v, 8'hFF);
        quiet();
        $display("reset test done");
        wr(8'h23, 8'hB0);
        wr(8'h18, 8'h01);
        check(8'(ref_amp_on), 8'h01);
        cyc(1500);
        for (int i = 0; i < 11; i++) begin
            rd(rows[i][15:8], v);
            check(v, rows[i][7:0]);
        end
        $display("sweep test done");
        wr(8'h1F, 8'h04);
        cyc(1500);
        rd(8'h07, v);
        check(v, 8'hFE);
        $display("offset test done");
        check(8'(int_out), 8'h00);
        wr(8'h18, 8'h09);
        cyc(2);
        check(8'(int_out), 8'h01);
        wr(8'h1E, 8'h01);
        rd(8'h01, v);
        cyc(200);
        rd(8'h01, v);
        check(v, 8'h00);
        check(8'(int_out), 8'h00);
        $display("interrupt test done");
        for (int s = 0; s < 8; s++) begin
            wr(8'h19, 8'h10 | 8'(s));
            next_start(c);
            next_start(c);
            check(8'(c), 8'(sel_chan[s]));
        end
        wr(8'h19, 8'h12);
        next_start(c);
        next_start(c);
        v[0] = diode_bias_high;
        next_start(c);
        check(8'(diode_bias_high ^ v[0]), 8'h01);
        check(8'(c), 8'h02);
        $display("single channel test done");
        wr(8'h19, 8'h00);
        wr(8'h18, 8'h0F);
        check(8'(shared_pins_analog), 8'h01);
        n = 0;
        m = 0;
        repeat (40) begin
            next_start(c);
            n += int'(c == 3'h4);
            m += int'(c == 3'h1);
        end
        check(8'(n > 0), 8'h01);
        check(8'(m > 8), 8'h01);
        wr(8'h19, 8'h20);
        wr(8'h1A, 8'h11);
        check(8'(dac_ref_internal), 8'h01);
        m = 0;
        repeat (12) begin
            next_start(c);
            m += int'(c == 3'h1);
            if (c >= 3'h3) begin
                check(8'(adc_ref_internal), 8'h00);
            end
        end
        check(8'(m < 5), 8'h01);
        $display("analog pin test done");
        next_start(c);
        serial_busy = 1'b1;
        n = 0;
        repeat (10) begin
            cyc(1);
            n += int'(adc_abort);
        end
        serial_busy = 1'b0;
        check(8'(n), 8'h01);
        next_start(c);
        rd(8'h0B, v);
        check(v, 8'h7F);
        $display("serial pause test done");
        wr(8'h18, 8'h00);
        check(8'(ref_amp_on), 8'h00);
        quiet();
        $display("disable test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
